//--- rtl/rssq_pkg.sv
// Purpose: Types shared by the reset sequencer
// Assumes: Nothing
// Notes: Oscillator codes follow the configuration bit pair
package rssq_pkg;

  typedef enum logic [1:0] {
    RSSQ_LOW_POWER_XTAL = 2'h0,
    RSSQ_CRYSTAL = 2'h1,
    RSSQ_HIGH_SPEED_XTAL = 2'h2,
    RSSQ_RES_CAP = 2'h3
  } rssq_osc_t;

  typedef enum logic [2:0] {
    RSSQ_CAUSE_POWER_ON,
    RSSQ_CAUSE_CLEAR_RUN,
    RSSQ_CAUSE_CLEAR_SLEEP,
    RSSQ_CAUSE_DOG_RESET,
    RSSQ_CAUSE_DOG_WAKE,
    RSSQ_CAUSE_BROWNOUT,
    RSSQ_CAUSE_IRQ_WAKE
  } rssq_cause_t;

  typedef enum {
    RSSQ_S_SUPPLY_WAIT,
    RSSQ_S_PWRUP_WAIT,
    RSSQ_S_OSC_WAIT,
    RSSQ_S_RUN,
    RSSQ_S_SLEEP
  } rssq_state_t;

endpackage

//--- rtl/rssq_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Core clock of 200 MHz
// Notes: Cycle counts derive from the times by rounding up
`ifndef RSSQ_REGS_SVH
`define RSSQ_REGS_SVH

`define RSSQ_CORE_MHZ 200

`define RSSQ_OFS_CFG 4'h0
`define RSSQ_OFS_STAT 4'h4

`define RSSQ_CFG_OSC_LO 0
`define RSSQ_CFG_OSC_HI 1
`define RSSQ_CFG_PWRUP_EN_N 3
`define RSSQ_CFG_BROWN_EN 6
`define RSSQ_CFG_BROWN_LVL 7
`define RSSQ_CFG_MASK 8'hCB
`define RSSQ_CFG_RST 8'hCB

`define RSSQ_STAT_SLEEP 0
`define RSSQ_STAT_TIMEOUT 1
`define RSSQ_STAT_CAUSE_LO 2
`define RSSQ_STAT_CAUSE_HI 4
`define RSSQ_STAT_RUN 5
`define RSSQ_STAT_REGRST 6

`define RSSQ_INTOSC_TICK_NS 1000
`define RSSQ_INTOSC_TICK_CYC \
  ((`RSSQ_INTOSC_TICK_NS * `RSSQ_CORE_MHZ + 999) / 1000)
`define RSSQ_PWRUP_MS 72
`define RSSQ_PWRUP_TICKS \
  (`RSSQ_PWRUP_MS * 1000000 / `RSSQ_INTOSC_TICK_NS)
`define RSSQ_OSCST_EDGES 1024
`define RSSQ_BROWN_MIN_NS 100000
`define RSSQ_BROWN_MIN_CYC \
  ((`RSSQ_BROWN_MIN_NS * `RSSQ_CORE_MHZ + 999) / 1000)
`define RSSQ_CLR_FILT_NS 100
`define RSSQ_CLR_FILT_CYC \
  ((`RSSQ_CLR_FILT_NS * `RSSQ_CORE_MHZ + 999) / 1000)

`endif

//--- rtl/rssq_reset_sequencer.sv
// Purpose: Reset cause tracking and power-up delay sequencing
// Assumes: Pins and comparators are asynchronous to core_clk
// Notes: Core clock keeps running while the core is held or asleep
`timescale 1ns/1ps
`include "rssq_regs.svh"

module rssq_reset_sequencer
  import rssq_pkg::*;
#(
  parameter int PwrupTicks = `RSSQ_PWRUP_TICKS,
  parameter int BrownMinCyc = `RSSQ_BROWN_MIN_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and supply comparators
  input wire logic masterClearN,
  input wire logic oscInputPin,
  input wire logic supplyPresent,
  input wire logic supplyAbove4v0,
  input wire logic supplyAbove2v5,
  // Core events
  input wire logic watchdogExpire,
  input wire logic sleepEnter,
  input wire logic wakeIrq,
  // Core control and status
  output logic coreRun,
  output logic regReset,
  output logic oscAmpEn,
  output logic [1:0] oscMode,
  output logic [2:0] resetCause,
  output logic timeoutFlag,
  output logic sleepFlag
);

  localparam int PwW = $clog2(PwrupTicks + 1);
  localparam int BrW = $clog2(BrownMinCyc + 1);
  localparam int DivW = $clog2(`RSSQ_INTOSC_TICK_CYC + 1);
  localparam int OscW = $clog2(`RSSQ_OSCST_EDGES + 1);
  localparam int ClrW = $clog2(`RSSQ_CLR_FILT_CYC + 1);

  if (PwrupTicks < 1 || BrownMinCyc < 1)
  begin : g_bad_param
    $error("Timer lengths must be at least one");
  end

  function automatic logic isCrystal(input rssq_osc_t m);
    isCrystal = (m != RSSQ_RES_CAP);
  endfunction

  logic [4:0] pinSync;
  logic clrSync;
  logic oscSync;
  logic supSync;
  logic hi4Sync;
  logic hi2Sync;
  logic [7:0] cfg_ff;
  rssq_osc_t curMode;
  logic pwrupEnN;
  logic brownEn;
  logic brownLvlHi;
  logic supplyOk;
  logic [DivW-1:0] div_ff;
  logic intTick;
  logic oscPrev_ff;
  logic supPrev_ff;
  logic oscEdge;
  logic porPulse;
  logic extClearLow;
  logic brownLow;
  logic pwrupDone;
  logic oscDone;
  rssq_state_t state_ff;
  rssq_state_t nxt_state;
  rssq_cause_t cause_ff;
  rssq_cause_t nxt_cause;
  logic timeout_ff;
  logic nxt_timeout;
  logic sleep_ff;
  logic nxt_sleep;
  logic pwrupReq_ff;
  logic nxt_pwrupReq;
  logic oscReq_ff;
  logic nxt_oscReq;
  logic fullReset;
  logic regReset_ff;
  logic coreRun_ff;
  logic oscAmp_ff;
  logic [1:0] oscMode_ff;
  logic busReq;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rdMux;

  // Every pin crosses two flops before use
  rssq_sync #(.W(5)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d({masterClearN, oscInputPin, supplyPresent,
        supplyAbove4v0, supplyAbove2v5}),
    .q(pinSync)
  );
  assign {clrSync, oscSync, supSync, hi4Sync, hi2Sync} = pinSync;

  assign curMode = rssq_osc_t'(
    cfg_ff[`RSSQ_CFG_OSC_HI:`RSSQ_CFG_OSC_LO]);
  assign pwrupEnN = cfg_ff[`RSSQ_CFG_PWRUP_EN_N];
  assign brownEn = cfg_ff[`RSSQ_CFG_BROWN_EN];
  assign brownLvlHi = cfg_ff[`RSSQ_CFG_BROWN_LVL];

  // Disabled brown-out logic reads as a healthy supply
  assign supplyOk = !brownEn ||
    (brownLvlHi ? hi4Sync : hi2Sync);

  // Tick restarts with each wait, so the first tick is a full one
  assign intTick = (div_ff == DivW'(`RSSQ_INTOSC_TICK_CYC - 1));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      div_ff <= '0;
    else if (intTick || state_ff != RSSQ_S_PWRUP_WAIT)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oscPrev_ff <= 1'b0;
      supPrev_ff <= 1'b0;
    end
    else
    begin
      oscPrev_ff <= oscSync;
      supPrev_ff <= supSync;
    end
  end

  // Pin edges count whether a crystal or an external clock drives it
  assign oscEdge = oscSync && !oscPrev_ff;
  assign porPulse = supSync && !supPrev_ff;

  // Low level must persist before it counts as a clear
  rssq_timer #(.W(ClrW)) u_clr_filt (
    .core_clk(core_clk),
    .resetn(resetn),
    .clr(clrSync),
    .en(1'b1),
    .len(ClrW'(`RSSQ_CLR_FILT_CYC)),
    .done(extClearLow)
  );

  rssq_timer #(.W(BrW)) u_brown_qual (
    .core_clk(core_clk),
    .resetn(resetn),
    .clr(supplyOk),
    .en(1'b1),
    .len(BrW'(BrownMinCyc)),
    .done(brownLow)
  );

  rssq_timer #(.W(PwW)) u_pwrup (
    .core_clk(core_clk),
    .resetn(resetn),
    .clr(state_ff != RSSQ_S_PWRUP_WAIT),
    .en(intTick),
    .len(PwW'(PwrupTicks)),
    .done(pwrupDone)
  );

  rssq_timer #(.W(OscW)) u_osc_start (
    .core_clk(core_clk),
    .resetn(resetn),
    .clr(state_ff != RSSQ_S_OSC_WAIT),
    .en(oscEdge),
    .len(OscW'(`RSSQ_OSCST_EDGES)),
    .done(oscDone)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    nxt_timeout = timeout_ff;
    nxt_sleep = sleep_ff;
    nxt_pwrupReq = pwrupReq_ff;
    nxt_oscReq = oscReq_ff;
    fullReset = 1'b0;
    if (porPulse)
    begin
      fullReset = 1'b1;
      nxt_cause = RSSQ_CAUSE_POWER_ON;
      nxt_timeout = 1'b1;
      nxt_sleep = 1'b1;
    end
    else if (brownLow && state_ff != RSSQ_S_SUPPLY_WAIT)
    begin
      fullReset = 1'b1;
      nxt_cause = RSSQ_CAUSE_BROWNOUT;
      nxt_timeout = 1'b1;
      nxt_sleep = 1'b1;
    end
    else
    begin
      case (state_ff)
        RSSQ_S_SUPPLY_WAIT:
          if (supplyOk && !extClearLow)
          begin
            if (pwrupReq_ff)
              nxt_state = RSSQ_S_PWRUP_WAIT;
            else if (oscReq_ff)
              nxt_state = RSSQ_S_OSC_WAIT;
            else
              nxt_state = RSSQ_S_RUN;
          end
        RSSQ_S_PWRUP_WAIT:
          if (!supplyOk)
          begin
            fullReset = 1'b1;
            nxt_cause = RSSQ_CAUSE_BROWNOUT;
            nxt_timeout = 1'b1;
            nxt_sleep = 1'b1;
          end
          else if (pwrupDone)
          begin
            nxt_pwrupReq = 1'b0;
            if (oscReq_ff)
              nxt_state = RSSQ_S_OSC_WAIT;
            else if (extClearLow)
              nxt_state = RSSQ_S_SUPPLY_WAIT;
            else
              nxt_state = RSSQ_S_RUN;
          end
        RSSQ_S_OSC_WAIT:
          if (oscDone)
          begin
            nxt_oscReq = 1'b0;
            if (extClearLow && regReset_ff)
              nxt_state = RSSQ_S_SUPPLY_WAIT;
            else
              nxt_state = RSSQ_S_RUN;
          end
        RSSQ_S_RUN:
          if (extClearLow)
          begin
            fullReset = 1'b1;
            nxt_cause = RSSQ_CAUSE_CLEAR_RUN;
          end
          else if (watchdogExpire)
          begin
            // Internal only: there is no drive path to the pin
            fullReset = 1'b1;
            nxt_cause = RSSQ_CAUSE_DOG_RESET;
            nxt_timeout = 1'b0;
            nxt_sleep = 1'b1;
          end
          else if (sleepEnter)
          begin
            nxt_state = RSSQ_S_SLEEP;
            nxt_timeout = 1'b1;
            nxt_sleep = 1'b0;
          end
        RSSQ_S_SLEEP:
          if (extClearLow)
          begin
            fullReset = 1'b1;
            nxt_cause = RSSQ_CAUSE_CLEAR_SLEEP;
            nxt_timeout = 1'b1;
            nxt_sleep = 1'b0;
          end
          else if (watchdogExpire || wakeIrq)
          begin
            nxt_cause = watchdogExpire ? RSSQ_CAUSE_DOG_WAKE :
              RSSQ_CAUSE_IRQ_WAKE;
            nxt_timeout = !watchdogExpire;
            nxt_sleep = 1'b0;
            nxt_oscReq = isCrystal(curMode);
            nxt_state = isCrystal(curMode) ? RSSQ_S_OSC_WAIT :
              RSSQ_S_RUN;
          end
        default:
          nxt_state = RSSQ_S_SUPPLY_WAIT;
      endcase
    end
    if (fullReset)
    begin
      nxt_state = RSSQ_S_SUPPLY_WAIT;
      nxt_pwrupReq = !pwrupEnN &&
        (nxt_cause == RSSQ_CAUSE_POWER_ON ||
         nxt_cause == RSSQ_CAUSE_BROWNOUT);
      // A dip during a power-on sequence keeps its start-up count
      nxt_oscReq = isCrystal(curMode) &&
        (nxt_cause == RSSQ_CAUSE_POWER_ON ||
         (nxt_cause == RSSQ_CAUSE_BROWNOUT && oscReq_ff));
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= RSSQ_S_SUPPLY_WAIT;
      cause_ff <= RSSQ_CAUSE_POWER_ON;
      pwrupReq_ff <= 1'b0;
      oscReq_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
      pwrupReq_ff <= nxt_pwrupReq;
      oscReq_ff <= nxt_oscReq;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timeout_ff <= 1'b1;
      sleep_ff <= 1'b1;
    end
    else
    begin
      timeout_ff <= nxt_timeout;
      sleep_ff <= nxt_sleep;
    end
  end

  // Immune registers get no reset line at all; wakes never raise this
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      regReset_ff <= 1'b1;
    else if (fullReset)
      regReset_ff <= 1'b1;
    else if (nxt_state == RSSQ_S_RUN)
      regReset_ff <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      coreRun_ff <= 1'b0;
    else
      coreRun_ff <= (nxt_state == RSSQ_S_RUN);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oscAmp_ff <= 1'b0;
      oscMode_ff <= 2'h3;
    end
    else
    begin
      oscAmp_ff <= isCrystal(curMode);
      oscMode_ff <= curMode;
    end
  end

  assign coreRun = coreRun_ff;
  assign regReset = regReset_ff;
  assign oscAmpEn = oscAmp_ff;
  assign oscMode = oscMode_ff;
  assign resetCause = cause_ff;
  assign timeoutFlag = timeout_ff;
  assign sleepFlag = sleep_ff;

  // One wait cycle on every access keeps decode off the bus path
  assign busReq = avs_read || avs_write;
  assign avs_waitrequest = busReq && !ack_ff;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= busReq && !ack_ff;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cfg_ff <= `RSSQ_CFG_RST;
    else if (avs_write && ack_ff && avs_byteenable[0] &&
             avs_address == `RSSQ_OFS_CFG)
      cfg_ff <= avs_writedata[7:0] & `RSSQ_CFG_MASK;
  end

  always_comb
  begin
    rdMux = 32'h0;
    if (avs_address == `RSSQ_OFS_CFG)
      rdMux[7:0] = cfg_ff;
    else if (avs_address == `RSSQ_OFS_STAT)
    begin
      rdMux[`RSSQ_STAT_SLEEP] = sleep_ff;
      rdMux[`RSSQ_STAT_TIMEOUT] = timeout_ff;
      rdMux[`RSSQ_STAT_CAUSE_HI:`RSSQ_STAT_CAUSE_LO] = cause_ff;
      rdMux[`RSSQ_STAT_RUN] = coreRun_ff;
      rdMux[`RSSQ_STAT_REGRST] = regReset_ff;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 32'h0;
    else if (avs_read && !ack_ff)
      rdata_ff <= rdMux;
  end

  assign avs_readdata = rdata_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_osc_decode: assert property (
    (cfg_ff[1:0] == 2'h3) |=> !oscAmpEn && oscMode == 2'h3)
    else $error("Resistor-cap mode left amplifier on");

  a_dog_wake_keep: assert property (
    (state_ff == RSSQ_S_SLEEP && watchdogExpire && !porPulse &&
     !brownLow && !extClearLow)
    |=> !regReset_ff && !timeoutFlag && !sleepFlag)
    else $error("Watchdog wake disturbed registers or flags");

  a_dog_reset_flags: assert property (
    (state_ff == RSSQ_S_RUN && watchdogExpire && !porPulse &&
     !brownLow && !extClearLow)
    |=> regReset_ff && !timeoutFlag && sleepFlag &&
        state_ff == RSSQ_S_SUPPLY_WAIT)
    else $error("Watchdog reset flags wrong");

  a_clear_filter: assert property (
    $rose(extClearLow) |-> !$past(clrSync, 2) && !$past(clrSync, 3))
    else $error("Short clear pulse accepted");

  a_hold_pwrup: assert property (
    (state_ff == RSSQ_S_PWRUP_WAIT) |-> regReset_ff && !coreRun)
    else $error("Core released during power-up wait");

  a_osc_start_mode: assert property (
    $rose(state_ff == RSSQ_S_OSC_WAIT) |-> $past(isCrystal(curMode)))
    else $error("Start-up count in resistor-cap mode");

  a_brown_qualify: assert property (
    $rose(brownLow) |-> !$past(supplyOk, 1) && !$past(supplyOk, 2))
    else $error("Brown-out raised without a sustained dip");

  a_wait_supply: assert property (
    (state_ff == RSSQ_S_SUPPLY_WAIT && !supplyOk)
    |=> state_ff == RSSQ_S_SUPPLY_WAIT && !coreRun)
    else $error("Left supply wait with low supply");

  a_pwrup_restart: assert property (
    (state_ff == RSSQ_S_PWRUP_WAIT && !supplyOk && !pwrupEnN)
    |=> state_ff == RSSQ_S_SUPPLY_WAIT && pwrupReq_ff)
    else $error("Dip did not restart power-up delay");

endmodule

//--- rtl/rssq_sync.sv
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow levels, not data words
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps

module rssq_sync
  import rssq_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  if (W < 1)
  begin : g_bad_w
    $error("Synchroniser width must be positive");
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule

//--- rtl/rssq_timer.sv
// Purpose: Saturating up-counter with registered completion
// Assumes: len is stable while the count runs
// Notes: done rises one edge after the count reaches len
`timescale 1ns/1ps

module rssq_timer
  import rssq_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] len,
  // Completion
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic done_ff;

  if (W < 1)
  begin : g_bad_w
    $error("Timer width must be positive");
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_ff <= '0;
    else if (clr)
      cnt_ff <= '0;
    else if (en && cnt_ff != len)
      cnt_ff <= cnt_ff + 1'b1;
  end

  // Registered so the release path never sees a compare glitch
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      done_ff <= 1'b0;
    else
      done_ff <= !clr && (cnt_ff == len);
  end

  assign done = done_ff;

endmodule

//--- tb/rssq_partner.sv
// Purpose: Pin and supply comparator model for the sequencer
// Assumes: supMode 0 off, 1 below 2.5V, 2 between, 3 above 4.0V
// Notes: Oscillator pin stands still while stopped
`timescale 1ns/1ps

module rssq_partner
(
  // Clock
  input wire logic core_clk,
  // Bench controls
  input wire logic [1:0] supMode,
  input wire logic clearHold,
  input wire logic oscOn,
  // Pins and comparators
  output logic masterClearN,
  output logic oscInputPin,
  output logic supplyPresent,
  output logic supplyAbove4v0,
  output logic supplyAbove2v5
);
  logic ph = 1'b0;
  logic oscLevel = 1'b0;
  assign masterClearN = !clearHold;
  assign supplyPresent = supMode != 2'h0;
  assign supplyAbove2v5 = supMode >= 2'h2;
  assign supplyAbove4v0 = supMode == 2'h3;
  assign oscInputPin = oscLevel;
  // One rising edge every four core cycles
  always @(posedge core_clk)
  begin
    ph <= !ph;
    if (oscOn && ph)
      oscLevel <= !oscLevel;
  end
endmodule

//--- tb/rssq_reset_sequencer_test.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short timer parameters, 200 MHz core clock
// Notes: Checks are taken 1 ns after the clock edge
`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
      err_count++; \
    end \
  end

module rssq_reset_sequencer_test;
  import rssq_pkg::*;
  localparam int PwrCyc = 4 * 200;
  logic core_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic masterClearN, oscInputPin, supplyPresent;
  logic supplyAbove4v0, supplyAbove2v5;
  logic watchdogExpire, sleepEnter, wakeIrq, clearHold, oscOn, r;
  logic coreRun, regReset, oscAmpEn, timeoutFlag, sleepFlag;
  logic [1:0] oscMode, supMode;
  logic [2:0] resetCause;
  int err_count = 0;
  int checked = 0;
  int n;

  rssq_reset_sequencer #(.PwrupTicks(4), .BrownMinCyc(8)) uut (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .masterClearN(masterClearN), .oscInputPin(oscInputPin),
    .supplyPresent(supplyPresent), .supplyAbove4v0(supplyAbove4v0),
    .supplyAbove2v5(supplyAbove2v5), .watchdogExpire(watchdogExpire),
    .sleepEnter(sleepEnter), .wakeIrq(wakeIrq), .coreRun(coreRun),
    .regReset(regReset), .oscAmpEn(oscAmpEn), .oscMode(oscMode),
    .resetCause(resetCause), .timeoutFlag(timeoutFlag),
    .sleepFlag(sleepFlag));

  rssq_partner far (
    .core_clk(core_clk), .supMode(supMode), .clearHold(clearHold),
    .oscOn(oscOn), .masterClearN(masterClearN),
    .oscInputPin(oscInputPin), .supplyPresent(supplyPresent),
    .supplyAbove4v0(supplyAbove4v0), .supplyAbove2v5(supplyAbove2v5));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    `CHK("busWait", 2, k)
  endtask

  task automatic waitrun(input int lim);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (coreRun !== 1'b1 && n < lim);
  endtask

  task automatic pulse(input int w);
    @(posedge core_clk);
    watchdogExpire <= (w == 0);
    sleepEnter <= (w == 1);
    wakeIrq <= (w == 2);
    @(posedge core_clk);
    {watchdogExpire, sleepEnter, wakeIrq} <= 3'h0;
    #1;
  endtask

  task automatic ck(input logic [2:0] c, input logic [1:0] f);
    `CHK("cause", c, resetCause)
    `CHK("flags", f, {timeoutFlag, sleepFlag})
  endtask

  // Supply at level m for c cycles; r is coreRun at the end of it
  task automatic dip(input logic [1:0] m, input int c, input int lim);
    @(posedge core_clk);
    supMode <= m;
    repeat (c) @(posedge core_clk);
    #1;
    r = coreRun;
    @(posedge core_clk);
    supMode <= 2'h3;
    waitrun(lim);
  endtask

  task automatic t_reset;
    `CHK("run", 2'h1, {coreRun, regReset})
    `CHK("oscMode", 2'h3, oscMode)
    ck(RSSQ_CAUSE_POWER_ON, 2'h3);
    bus(1'b0, 4'h0, 8'h0, rd);
    `CHK("cfg", 32'hCB, rd)
    bus(1'b0, 4'h8, 8'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    @(posedge core_clk);
    supMode <= 2'h3;
    waitrun(60);
    `CHK("porRun", 2'h2, {coreRun, regReset})
    ck(RSSQ_CAUSE_POWER_ON, 2'h3);
    bus(1'b0, 4'h4, 8'h0, rd);
    `CHK("status", 32'h23, rd)
    $display("test reset done");
  endtask

  task automatic t_events;
    pulse(0);
    `CHK("dogHold", 2'h1, {coreRun, regReset})
    waitrun(5);
    ck(RSSQ_CAUSE_DOG_RESET, 2'h1);
    pulse(1);
    `CHK("asleep", 3'h2, {coreRun, timeoutFlag, sleepFlag})
    pulse(0);
    `CHK("wakeKeep", 1'b0, regReset)
    waitrun(5);
    ck(RSSQ_CAUSE_DOG_WAKE, 2'h0);
    pulse(1);
    pulse(2);
    waitrun(5);
    ck(RSSQ_CAUSE_IRQ_WAKE, 2'h2);
    $display("test events done");
  endtask

  task automatic hold(input int c);
    @(posedge core_clk);
    clearHold <= 1'b1;
    repeat (c) @(posedge core_clk);
    clearHold <= 1'b0;
    #1;
  endtask

  task automatic t_clear;
    hold(10);
    repeat (30) @(posedge core_clk);
    #1;
    `CHK("shortClear", 2'h2, {coreRun, regReset})
    hold(40);
    `CHK("longClear", 2'h1, {coreRun, regReset})
    waitrun(60);
    ck(RSSQ_CAUSE_CLEAR_RUN, 2'h2);
    pulse(1);
    hold(40);
    `CHK("sleepClear", 2'h1, {coreRun, regReset})
    waitrun(60);
    ck(RSSQ_CAUSE_CLEAR_SLEEP, 2'h2);
    $display("test clear done");
  endtask

  task automatic t_brown;
    bus(1'b1, 4'h0, 8'h4B, rd);
    dip(2'h2, 40, 60);
    `CHK("lowLevel", 1'b1, r)
    dip(2'h1, 5, 60);
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("shortDip", 1'b1, coreRun)
    dip(2'h1, 30, 60);
    `CHK("longDip", 1'b0, r)
    ck(RSSQ_CAUSE_BROWNOUT, 2'h3);
    bus(1'b1, 4'h0, 8'h0B, rd);
    dip(2'h1, 30, 60);
    `CHK("disabled", 1'b1, r)
    bus(1'b1, 4'h0, 8'hCB, rd);
    dip(2'h2, 30, 60);
    `CHK("highLevel", 1'b0, r)
    $display("test brown done");
  endtask

  task automatic t_pwrup;
    bus(1'b1, 4'h0, 8'h43, rd);
    dip(2'h0, 10, 2000);
    `CHK("pwrupLen", 1'b1, n >= PwrCyc && n <= PwrCyc + 40)
    @(posedge core_clk);
    supMode <= 2'h0;
    repeat (10) @(posedge core_clk);
    supMode <= 2'h3;
    repeat (400) @(posedge core_clk);
    dip(2'h1, 4, 2000);
    `CHK("restart", 1'b1, n >= PwrCyc && n <= PwrCyc + 40)
    ck(RSSQ_CAUSE_BROWNOUT, 2'h3);
    $display("test pwrup done");
  endtask

  task automatic t_xtal;
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, 4'h0, 8'h48 | m[7:0], rd);
      @(posedge core_clk);
      #1;
      `CHK("oscMode", m[1:0], oscMode)
      `CHK("oscAmpEn", m != 3, oscAmpEn)
    end
    bus(1'b1, 4'h0, 8'h41, rd);
    dip(2'h0, 10, 1500);
    `CHK("oscWait", 1'b0, coreRun)
    @(posedge core_clk);
    oscOn <= 1'b1;
    waitrun(5000);
    `CHK("oscLen", 1'b1, n >= 4090 && n <= 4140)
    bus(1'b1, 4'h0, 8'h49, rd);
    @(posedge core_clk);
    oscOn <= 1'b0;
    pulse(0);
    waitrun(10);
    `CHK("dogNoCount", 1'b1, coreRun)
    $display("test xtal done");
  endtask

  // Tests need about 10000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    wrap_up;
  end

  initial
  begin
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {watchdogExpire, sleepEnter, wakeIrq, clearHold, oscOn} = '0;
    supMode = 2'h0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset;
    t_events;
    t_clear;
    t_brown;
    t_pwrup;
    t_xtal;
    wrap_up;
  end
endmodule
